// file: rtl/ibc_defs.svh
`ifndef IBC_DEFS_SVH
`define IBC_DEFS_SVH

// ****************************************************************
// Interrupt levels
// ****************************************************************
`define IBC_LVL_NONE        3'h0
`define IBC_LVL_NMI         3'h7
`define IBC_NUM_LINES       7

// ****************************************************************
// Jumper defaults for the on-board sources
// ****************************************************************
`define IBC_JMP_REFRESH_DEF 3'h7
`define IBC_JMP_UTIMER_DEF  3'h6
`define IBC_JMP_SERIAL_DEF  3'h5

// ****************************************************************
// Address decode, 24-bit byte addresses
// ****************************************************************
`define IBC_OVERLAY_TOP     24'h00_8000
`define IBC_PROM_PAGE_MASK  24'hFF_0000
`define IBC_PROM_PAGE       24'h10_0000
`define IBC_BOOT_LEAVE_ADDR 24'h20_0000

// ****************************************************************
// Synchroniser width for pin inputs
// ****************************************************************
`define IBC_SYNC_WIDTH      19

`endif

// file: rtl/ibc_pkg.sv
// ****************************************************************
// Types shared by the interrupt and boot control
// ****************************************************************
package ibc_pkg;
	typedef logic [2:0] ibc_level_t;
	typedef logic [7:1] ibc_lines_t;
	typedef logic [23:0] ibc_addr_t;

	// Address space of a processor cycle, as resolved by the translator
	typedef enum logic [1:0] {
		IBC_SP_LOCAL_MEM,
		IBC_SP_BUS_MEM,
		IBC_SP_BUS_IO,
		IBC_SP_SYSTEM
	} ibc_space_e;

	// Boot state of the board
	typedef enum logic {
		IBC_MODE_BOOT,
		IBC_MODE_RUN
	} ibc_mode_e;
endpackage : ibc_pkg

// file: rtl/ibc_irq_if.sv
`timescale 1ns/100ps
// ****************************************************************
// Request lines toward the level encoder and its answer
// ****************************************************************
interface ibc_irq_if;
	import ibc_pkg::*;
	ibc_lines_t req;
	logic       suppress;
	ibc_level_t level;

	modport enc
	(
		input  req,
		input  suppress,
		output level
	);
	modport ctl
	(
		output req,
		output suppress,
		input  level
	);
endinterface : ibc_irq_if

// file: rtl/ibc_level_enc.sv
`timescale 1ns/100ps
// ****************************************************************
// Priority encoder: most urgent active line to a level code
// ****************************************************************
module ibc_level_enc
(
	ibc_irq_if.enc irq
);
	import ibc_pkg::*;

	// Scan upward so the highest active line wins
	always_comb
	begin
		irq.level = 3'h0;
		for (int i = 1; i <= 7; i++)
		begin
			if (irq.req[i] && !irq.suppress)
			begin
				irq.level = 3'(i);
			end
		end
	end
endmodule : ibc_level_enc

// file: rtl/ibc_top.sv
`timescale 1ns/100ps
// Contract
// - Seven levels, seven most urgent, zero means nothing pending.
// - Level seven is edge triggered; each rise to seven acknowledges anew.
// - Bus lines map straight to levels; line zero is ignored.
// - Lines one to six level sensitive and shareable; seven is the exception.
// - Refresh timer seven, user timer six, serial five; jumpers may reassign.
// - Acknowledge by auto-vector; bus acknowledge and vector transfer unused.
// - Every hardware reset enters boot state.
// - In boot state PROM also appears at address zero over RAM.
// - In boot state RAM and bus reads blocked, writes still complete.
// - Boot state suppresses every interrupt, level seven included.
// - After boot, level seven any time, lower ones when mask allows.
// - One write to the boot leave location ends boot state.
`include "ibc_defs.svh"

module ibc_top
(
	input  wire logic               CORE_CLK,
	input  wire logic               SRST,
	input  wire ibc_pkg::ibc_lines_t BUS_INT_N,
	input  wire logic               REFRESH_IRQ,
	input  wire logic               UTIMER_IRQ,
	input  wire logic               SERIAL_IRQ,
	input  wire ibc_pkg::ibc_level_t JMP_REFRESH,
	input  wire ibc_pkg::ibc_level_t JMP_UTIMER,
	input  wire ibc_pkg::ibc_level_t JMP_SERIAL,
	input  wire logic               CPU_AS,
	input  wire logic               CPU_RW,
	input  wire logic               CPU_IACK,
	input  wire ibc_pkg::ibc_space_e CPU_SPACE,
	input  wire ibc_pkg::ibc_addr_t  CPU_ADDR,
	output ibc_pkg::ibc_level_t     CPU_IPL,
	output logic                    CPU_AVEC,
	output logic                    PROM_SEL,
	output logic                    RAM_SEL,
	output logic                    BUS_SEL,
	output logic                    READ_BLOCKED,
	output logic                    BUS_INTA_N,
	output logic                    BOOT_STATE
);
	import ibc_pkg::*;

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	logic [`IBC_SYNC_WIDTH-1:0] sync_in;
	logic [`IBC_SYNC_WIDTH-1:0] sync_meta;
	logic [`IBC_SYNC_WIDTH-1:0] sync_out;

	// Gather every asynchronous pin into one vector
	assign sync_in = {~BUS_INT_N, REFRESH_IRQ, UTIMER_IRQ, SERIAL_IRQ,
		JMP_REFRESH, JMP_UTIMER, JMP_SERIAL};

	// Two flops per pin before any logic looks at it
	genvar g;
	generate
		for (g = 0; g < `IBC_SYNC_WIDTH; g++)
		begin : g_sync
			always_ff @(posedge CORE_CLK)
			begin
				if (SRST)
				begin
					sync_meta[g] <= 1'b0;
					sync_out[g]  <= 1'b0;
				end
				else
				begin
					sync_meta[g] <= sync_in[g];
					sync_out[g]  <= sync_meta[g];
				end
			end
		end
	endgenerate

	ibc_lines_t bus_lines;
	logic       refresh_req;
	logic       utimer_req;
	logic       serial_req;
	ibc_level_t sel_refresh;
	ibc_level_t sel_utimer;
	ibc_level_t sel_serial;

	// Unpack the synchronised vector
	assign bus_lines   = sync_out[18:12];
	assign refresh_req = sync_out[11];
	assign utimer_req  = sync_out[10];
	assign serial_req  = sync_out[9];
	assign sel_refresh = sync_out[8:6];
	assign sel_utimer  = sync_out[5:3];
	assign sel_serial  = sync_out[2:0];

	// ****************************************************************
	// Boot state
	// ****************************************************************
	ibc_mode_e mode;
	logic      cyc_write;
	logic      leave_hit;

	assign cyc_write = CPU_AS && !CPU_RW && !CPU_IACK;
	assign leave_hit = cyc_write && (CPU_SPACE == IBC_SP_SYSTEM)
		&& (CPU_ADDR == `IBC_BOOT_LEAVE_ADDR);

	// Reset enters boot; one leave write exits until the next reset
	always_ff @(posedge CORE_CLK)
	begin
		if (SRST)
		begin
			mode <= IBC_MODE_BOOT;
		end
		else
		begin
			case (mode)
				IBC_MODE_BOOT:
				begin
					if (leave_hit)
					begin
						mode <= IBC_MODE_RUN;
					end
				end
				IBC_MODE_RUN:
				begin
					mode <= IBC_MODE_RUN;
				end
				default:
				begin
					mode <= IBC_MODE_BOOT;
				end
			endcase
		end
	end

	logic booting;
	assign booting    = (mode == IBC_MODE_BOOT);
	assign BOOT_STATE = booting;

	// ****************************************************************
	// Request merge and level presentation
	// ****************************************************************
	ibc_irq_if irq ();
	ibc_lines_t onboard;

	// Route each on-board source to the line its jumper picks; zero is open
	always_comb
	begin
		onboard = 7'h00;
		for (int i = 1; i <= 7; i++)
		begin
			onboard[i] = (refresh_req && (sel_refresh == 3'(i)))
				|| (utimer_req && (sel_utimer == 3'(i)))
				|| (serial_req && (sel_serial == 3'(i)));
		end
	end

	// Shared lines are wired-or levels; bus line n feeds level n
	assign irq.req      = bus_lines | onboard;
	assign irq.suppress = booting;

	ibc_level_enc u_enc
	(
		.irq (irq)
	);

	// Present the encoded level from a flop; edge on seven is left to the core
	always_ff @(posedge CORE_CLK)
	begin
		if (SRST)
		begin
			CPU_IPL <= `IBC_LVL_NONE;
		end
		else
		begin
			CPU_IPL <= irq.level;
		end
	end

	// ****************************************************************
	// Acknowledge
	// ****************************************************************
	// Every acknowledge cycle is auto-vectored; bus acknowledge stays idle
	assign CPU_AVEC   = CPU_AS && CPU_IACK;
	assign BUS_INTA_N = 1'b1;

	// ****************************************************************
	// Memory decode with boot overlay
	// ****************************************************************
	logic cyc;
	logic cyc_read;
	logic low_hit;
	logic prom_home;

	assign cyc       = CPU_AS && !CPU_IACK;
	assign cyc_read  = cyc && CPU_RW;
	assign low_hit   = (CPU_SPACE == IBC_SP_LOCAL_MEM) && (CPU_ADDR < `IBC_OVERLAY_TOP);
	assign prom_home = (CPU_SPACE == IBC_SP_SYSTEM)
		&& ((CPU_ADDR & `IBC_PROM_PAGE_MASK) == `IBC_PROM_PAGE);

	// Chip selects; boot reads at zero go to PROM, other RAM and bus reads blocked
	always_comb
	begin
		PROM_SEL     = cyc_read && (prom_home || (booting && low_hit));
		RAM_SEL      = cyc && (CPU_SPACE == IBC_SP_LOCAL_MEM)
			&& !(booting && CPU_RW);
		BUS_SEL      = cyc && ((CPU_SPACE == IBC_SP_BUS_MEM) || (CPU_SPACE == IBC_SP_BUS_IO))
			&& !(booting && CPU_RW);
		READ_BLOCKED = cyc_read && booting && !low_hit
			&& (CPU_SPACE != IBC_SP_SYSTEM);
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	AST_BOOT_AFTER_RESET: assert property (@(posedge CORE_CLK)
		SRST |=> BOOT_STATE)
		else $error("boot state not entered after reset");

	AST_BOOT_STICKY: assert property (@(posedge CORE_CLK) disable iff (SRST)
		!BOOT_STATE |=> !BOOT_STATE)
		else $error("boot state came back without reset");

	AST_BOOT_LEAVE: assert property (@(posedge CORE_CLK) disable iff (SRST)
		BOOT_STATE && leave_hit |=> !BOOT_STATE)
		else $error("leave write did not end boot state");

	AST_BOOT_HOLD: assert property (@(posedge CORE_CLK) disable iff (SRST)
		BOOT_STATE && !leave_hit |=> BOOT_STATE)
		else $error("boot state ended without leave write");

	AST_SUPPRESS: assert property (@(posedge CORE_CLK) disable iff (SRST)
		BOOT_STATE |=> (CPU_IPL == 3'h0))
		else $error("interrupt presented during boot state");

	AST_NMI_DELIVER: assert property (@(posedge CORE_CLK) disable iff (SRST)
		!BOOT_STATE && bus_lines[7] |=> (CPU_IPL == 3'h7))
		else $error("level seven not presented after boot");

	AST_LINE_SIX: assert property (@(posedge CORE_CLK) disable iff (SRST)
		!BOOT_STATE && bus_lines[6] && !irq.req[7] |=> (CPU_IPL == 3'h6))
		else $error("bus line six not presented as level six");

	AST_IDLE_ZERO: assert property (@(posedge CORE_CLK) disable iff (SRST)
		(irq.req == 7'h00) |=> (CPU_IPL == 3'h0))
		else $error("level presented with no request");

	AST_PIN_LATENCY: assert property (@(posedge CORE_CLK) disable iff (SRST)
		!BOOT_STATE && !BUS_INT_N[7] [*3] ##0 !BOOT_STATE |=> (CPU_IPL == 3'h7))
		else $error("level seven pin not seen within three edges");

	AST_OVERLAY: assert property (@(posedge CORE_CLK) disable iff (SRST)
		BOOT_STATE && cyc_read && low_hit |-> PROM_SEL && !RAM_SEL)
		else $error("boot read at zero not served by PROM");

	AST_READ_BLOCK: assert property (@(posedge CORE_CLK) disable iff (SRST)
		BOOT_STATE && cyc_read |-> !RAM_SEL && !BUS_SEL)
		else $error("read reached RAM or bus in boot state");

	AST_WRITE_PASS: assert property (@(posedge CORE_CLK) disable iff (SRST)
		cyc_write && (CPU_SPACE == IBC_SP_LOCAL_MEM) |-> RAM_SEL)
		else $error("RAM write refused");

	AST_AUTOVEC: assert property (@(posedge CORE_CLK) disable iff (SRST)
		CPU_AS && CPU_IACK |-> CPU_AVEC && BUS_INTA_N && !PROM_SEL && !RAM_SEL)
		else $error("acknowledge not auto-vectored");
endmodule : ibc_top

// file: verification/ibc_core_model.sv
`timescale 1ns/100ps
// ****************************************************************
// Processor core model: level compare, mask update, auto-vector ack
// ****************************************************************
module ibc_core_model
(
	input  wire logic                clk,
	input  wire logic                srst,
	input  wire ibc_pkg::ibc_level_t ipl,
	input  wire logic                avec,
	input  wire logic                lower,
	output logic                     as_o,
	output logic                     iack,
	output ibc_pkg::ibc_level_t      mask,
	output int                       acks
);
	import ibc_pkg::*;
	ibc_level_t prev;

	// Mask starts at seven; an ack holds its cycle until the answer is seen
	always_ff @(posedge clk)
	begin
		prev <= ipl;
		if (srst)
		begin
			as_o <= 1'b0;
			iack <= 1'b0;
			mask <= 3'h7;
			acks <= 0;
		end
		else if (iack)
		begin
			if (avec) // Vector made inside the core, no device vector
			begin
				as_o <= 1'b0;
				iack <= 1'b0;
				acks <= acks + 1;
			end
		end
		else if (lower)
			mask <= 3'h0;
		else if (ipl > mask || (ipl == 3'h7 && prev != 3'h7))
		begin
			as_o <= 1'b1;
			iack <= 1'b1;
			mask <= ipl; // Mask rises to the taken level
		end
	end
endmodule : ibc_core_model

// file: verification/interrupt_and_boot_control_tb_top.sv
`timescale 1ns/100ps
`include "ibc_defs.svh"
// ****************************************************************
// Bench for the interrupt and boot control
// ****************************************************************
module interrupt_and_boot_control_tb_top;
	import ibc_pkg::*;
	logic        CORE_CLK, SRST, REFRESH_IRQ, UTIMER_IRQ, SERIAL_IRQ, tb_as, CPU_RW;
	logic        CPU_AVEC, PROM_SEL, RAM_SEL, BUS_SEL, READ_BLOCKED, BUS_INTA_N, BOOT_STATE;
	logic        core_as, core_iack, smp, seen, lower;
	ibc_lines_t  BUS_INT_N;
	ibc_level_t  JMP_REFRESH, JMP_UTIMER, JMP_SERIAL, CPU_IPL, mask;
	ibc_space_e  CPU_SPACE;
	ibc_addr_t   CPU_ADDR;
	logic [19:0] q[$];
	logic [19:0] e;
	logic [31:0] r;
	logic [9:0]  obs;
	int          failures, n_checks, acks, seed, i;
	// Cycle table: read/write nibble, space nibble, address
	logic [31:0] tab[6] = '{32'h1000_0000, 32'h1000_8000, 32'h0000_0000,
		32'h1100_0000, 32'h0200_0000, 32'h1310_0004};
	logic [3:0]  exp_boot[6] = '{4'h1, 4'h8, 4'h2, 4'h8, 4'h4, 4'h1};
	logic [3:0]  exp_run[6] = '{4'h2, 4'h2, 4'h2, 4'h4, 4'h4, 4'h1};

	assign obs = {BOOT_STATE, BUS_INTA_N, READ_BLOCKED, BUS_SEL, RAM_SEL, PROM_SEL, CPU_AVEC,
		CPU_IPL};

	ibc_top i_dut (.CORE_CLK(CORE_CLK), .SRST(SRST), .BUS_INT_N(BUS_INT_N),
		.REFRESH_IRQ(REFRESH_IRQ), .UTIMER_IRQ(UTIMER_IRQ), .SERIAL_IRQ(SERIAL_IRQ),
		.JMP_REFRESH(JMP_REFRESH), .JMP_UTIMER(JMP_UTIMER), .JMP_SERIAL(JMP_SERIAL),
		.CPU_AS(tb_as | core_as), .CPU_RW(CPU_RW), .CPU_IACK(core_iack), .CPU_SPACE(CPU_SPACE),
		.CPU_ADDR(CPU_ADDR), .CPU_IPL(CPU_IPL), .CPU_AVEC(CPU_AVEC), .PROM_SEL(PROM_SEL),
		.RAM_SEL(RAM_SEL), .BUS_SEL(BUS_SEL), .READ_BLOCKED(READ_BLOCKED),
		.BUS_INTA_N(BUS_INTA_N), .BOOT_STATE(BOOT_STATE));

	ibc_core_model i_core (.clk(CORE_CLK), .srst(SRST), .ipl(CPU_IPL), .avec(CPU_AVEC),
		.lower(lower), .as_o(core_as), .iack(core_iack), .mask(mask), .acks(acks));

	// Clock at 10 MHz
	initial
	begin
		CORE_CLK = 1'b0;
		forever #50 CORE_CLK = ~CORE_CLK;
	end

	task cmp(input logic [31:0] got, input logic [31:0] want);
		n_checks++;
		if (got !== want)
		begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
		end
	endtask : cmp

	task end_of_test;
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_of_test

	task automatic cyc(input int n);
		repeat (n) @(posedge CORE_CLK);
	endtask : cyc

	// Note the expected outputs; the monitor compares them on the falling edge before the rising edge this waits for
	task automatic chk(input logic [9:0] m, input logic [9:0] x);
		q.push_back({m, x});
		smp <= ~smp;
		@(posedge CORE_CLK);
	endtask : chk

	task automatic bus(input logic rw, input logic [1:0] sp, input ibc_addr_t a);
		tb_as <= 1'b1;
		CPU_RW <= rw;
		CPU_SPACE <= ibc_space_e'(sp);
		CPU_ADDR <= a;
	endtask : bus

	task automatic decode(input logic run);
		for (int k = 0; k < 6; k++)
		begin
			bus(tab[k][28], tab[k][25:24], tab[k][23:0]);
			chk(10'h3f8, {~run, 1'b1, run ? exp_run[k] : exp_boot[k], 4'h0});
		end
	endtask : decode

	// Most urgent active line after jumper routing
	function automatic ibc_level_t want();
		ibc_lines_t l;
		ibc_level_t v;
		l = ~BUS_INT_N;
		if (REFRESH_IRQ && JMP_REFRESH != 3'h0) l[JMP_REFRESH] = 1'b1;
		if (UTIMER_IRQ && JMP_UTIMER != 3'h0) l[JMP_UTIMER] = 1'b1;
		if (SERIAL_IRQ && JMP_SERIAL != 3'h0) l[JMP_SERIAL] = 1'b1;
		v = 3'h0;
		for (int k = 1; k < 8; k++)
			if (l[k]) v = k[2:0];
		return v;
	endfunction : want

	// Monitor: one noted expectation per sample
	always @(negedge CORE_CLK)
		if (smp !== seen)
		begin
			seen = smp;
			e = q.pop_front();
			cmp({22'h0, obs & e[19:10]}, {22'h0, e[9:0]});
		end

	// Watchdog
	initial
	begin
		repeat (3000) @(posedge CORE_CLK);
		failures++;
		end_of_test;
	end

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial
	begin
		seed = 32'hf42e_5d67;
		{SRST, BUS_INT_N, REFRESH_IRQ, UTIMER_IRQ, SERIAL_IRQ} = 11'h7f8;
		{JMP_REFRESH, JMP_UTIMER, JMP_SERIAL} = 9'h1f5;
		{tb_as, CPU_RW, smp, seen, lower} = 5'h08;
		CPU_SPACE = IBC_SP_LOCAL_MEM;
		CPU_ADDR = 24'h00_0000;
		cyc(8);
		SRST <= 1'b0;
		chk(10'h3ff, 10'h300);
		$display("test reset done");
		BUS_INT_N[7] <= 1'b0;
		REFRESH_IRQ <= 1'b1;
		cyc(4);
		chk(10'h207, 10'h200);
		decode(1'b0);
		bus(1'b0, 2'h3, `IBC_BOOT_LEAVE_ADDR + 24'h2);
		chk(10'h200, 10'h200);
		bus(1'b0, 2'h3, `IBC_BOOT_LEAVE_ADDR);
		chk(10'h200, 10'h200);
		tb_as <= 1'b0;
		chk(10'h207, 10'h000);
		chk(10'h207, 10'h007);
		$display("test boot done");
		cyc(4);
		cmp(acks, 1);
		cyc(6);
		cmp(acks, 1);
		decode(1'b1);
		tb_as <= 1'b0;
		BUS_INT_N <= 7'h5f;
		REFRESH_IRQ <= 1'b0;
		cyc(6);
		cmp(acks, 1);
		lower <= 1'b1;
		cyc(1);
		lower <= 1'b0;
		cyc(4);
		cmp(acks, 2);
		cmp(mask, 6);
		BUS_INT_N[7] <= 1'b0;
		cyc(6);
		cmp(acks, 3);
		$display("test core done");
		for (i = 0; i < 40; i++)
		begin
			r = $random(seed);
			BUS_INT_N <= r[6:0];
			{REFRESH_IRQ, UTIMER_IRQ, SERIAL_IRQ} <= r[9:7];
			if (i > 7)
				{JMP_REFRESH, JMP_UTIMER, JMP_SERIAL} <= r[18:10];
			cyc(3);
			chk(10'h207, {7'h0, want()});
		end
		$display("test levels done");
		SRST <= 1'b1;
		BUS_INT_N[7] <= 1'b0;
		cyc(3);
		SRST <= 1'b0;
		chk(10'h207, 10'h200);
		cyc(3);
		chk(10'h207, 10'h200);
		$display("test second reset done");
		end_of_test;
	end
endmodule : interrupt_and_boot_control_tb_top
